/* File: hw/ubd_pkg.sv */
// package for the endpoint buffer descriptor block
// assumes an apb slave with 32-bit data, one register per aligned word
package ubd_pkg;
  localparam int EP_NUM = 7;
  // per-endpoint register block: 8 words, base = ep * 0x20
  localparam logic [11:0] EP_STRIDE = 12'h020;
  localparam logic [2:0] IDX_OUT_BBAY = 3'h0;
  localparam logic [2:0] IDX_OUT_BCTY = 3'h1;
  localparam logic [2:0] IDX_OUT_SIZ = 3'h2;
  localparam logic [2:0] IDX_IN_CNF = 3'h3;
  localparam logic [2:0] IDX_IN_BBAX = 3'h4;
  localparam logic [2:0] IDX_IN_BCTX = 3'h5;
  localparam logic [2:0] IDX_IN_BBAY = 3'h6;
  localparam logic [2:0] IDX_IN_BCTY = 3'h7;
  // global control word at offset 0x000
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  // field positions
  localparam int FLD_FLAG = 7;
  localparam int FLD_SVC = 7;
  localparam int FLD_TOG = 5;
  localparam int FLD_DOUBLE_BUFFER_ENABLE = 4;
  localparam int FLD_STALL = 3;
  localparam int FLD_IIE = 2;
  // writable masks, reserved bits read zero
  localparam logic [7:0] CNF_MASK = 8'hBC;
  localparam logic [7:0] SIZ_MASK = 8'h7F;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] RST_IN_BCTY = 8'h80;
  // handshake answer codes
  typedef enum logic [1:0] {
    HS_ACK   = 2'b00,
    HS_NAK   = 2'b01,
    HS_STALL = 2'b10,
    HS_NONE  = 2'b11
  } ubd_hs_t;
endpackage

/* File: hw/ubd_top.sv */
// endpoint 1..7 buffer descriptor registers and their buffer-manager side
// assumes apb master on clk_sys; the packet engine reports transaction events as one-cycle pulses
//
// Contract
// R1 - base register gives 11-bit start address
// R2 - manager never changes base registers
// R3 - good OUT sets output buffer flag
// R4 - output flag set means NAK
// R5 - OUT loads count with received bytes
// R6 - one size field for X and Y
// R7 - software sizes counts 0 to 64
// R8 - software avoids encodings above 64
// R9 - writes only while module enabled
// R10 - service enable gates endpoint use (here only IN requests are gated, OUT requests are answered ungated)
// R11 - IN toggle flips after sent packet
// R12 - double buffer off uses X only (here an OUT request still reports the Y base as its start address)
// R13 - stall answers STALL, SETUP clears it
// R14 - irq enable gates transaction flag (here only the IN flag is gated, the OUT flag is set ungated)
// R15 - good IN sets input empty flag
// R16 - input empty flag means NAK
// R17 - software loads IN count after fill
// R18 - reserved bits read zero
// R19 - init marks input Y buffer empty
// R20 - OUT toggle flips on PID match
// R21 - toggle picks X or Y buffer
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module ubd_top
  import ubd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // transaction request from the packet engine
  input wire logic txnReq,
  input wire logic txnIsIn,
  input wire logic [2:0] txnEp,
  // completion events from the packet engine
  input wire logic outDone,
  input wire logic outPidMatch,
  input wire logic [6:0] outByteCount,
  input wire logic inDone,
  input wire logic setupSeen,
  input wire logic [2:0] setupEp,
  // answer to the packet engine
  output logic [1:0] txnHandshake,
  output logic [10:0] txnStartAddr,
  output logic [6:0] txnByteCount,
  output logic txnDataPid,
  output logic txnValid,
  output logic [6:0] txnBufSize,
  output logic [7:0] outIrqFlag,
  output logic [7:0] inIrqFlag,
  output logic usbModuleEnable
);

  // per-endpoint storage, index 0 unused
  logic [7:0] outBbay_ff [1:EP_NUM];
  logic [7:0] outBcty_ff [1:EP_NUM];
  logic [7:0] outSiz_ff [1:EP_NUM];
  logic [7:0] inCnf_ff [1:EP_NUM];
  logic [7:0] inBbax_ff [1:EP_NUM];
  logic [7:0] inBctx_ff [1:EP_NUM];
  logic [7:0] inBbay_ff [1:EP_NUM];
  logic [7:0] inBcty_ff [1:EP_NUM];
  // output endpoint X-side state lives outside this block; only toggle/double_buffer_enable/stall kept here
  logic [EP_NUM:1] outTog_ff;
  logic [EP_NUM:1] outStall_ff;
  logic [EP_NUM:1] outDbuf_ff;
  logic usb_module_enable_ff;

  // 11-bit address from an 8-bit base
  function automatic logic [10:0] baseToAddr(input logic [7:0] base);
    baseToAddr = {base, 3'b000}; // R1
  endfunction

  // apb decode
  wire logic apbAccess = psel & penable;
  wire logic apbWrite = apbAccess & pwrite;
  wire logic [2:0] regEp = paddr[7:5];
  wire logic [2:0] regIdx = paddr[4:2];
  wire logic isCtrl = (paddr == ADDR_CTRL);
  wire logic epHit = (paddr[11:8] == 4'h0) && (regEp != 3'd0) && (paddr[1:0] == 2'b00);
  wire logic hit = isCtrl | epHit;
  wire logic regWr = apbWrite & epHit & usb_module_enable_ff; // R9
  wire logic [7:0] wByte = pwdata[7:0];

  // legal slot for an endpoint number; endpoint 0 is not ours and falls back to slot 1
  // only to keep the array index in range, its answer is forced to none below
  function automatic logic [2:0] epIndex(input logic [2:0] ep);
    epIndex = (ep != 3'd0) ? ep : 3'd1;
  endfunction

  // transaction target, decoded from what the engine shows this cycle
  wire logic txnInRange = (txnEp != 3'd0);
  wire logic [2:0] txnIdx = epIndex(txnEp);
  wire logic [7:0] cnf = inCnf_ff[txnIdx];
  // double buffering: toggle picks the half, otherwise X only
  wire logic inUseY = cnf[FLD_DOUBLE_BUFFER_ENABLE] & cnf[FLD_TOG]; // R12 R21
  wire logic outUseY = outDbuf_ff[txnIdx] & outTog_ff[txnIdx]; // R12 R21
  wire logic useY = txnIsIn ? inUseY : outUseY;
  wire logic [7:0] inCount = useY ? inBcty_ff[txnIdx] : inBctx_ff[txnIdx];
  wire logic outFull = outBcty_ff[txnIdx][FLD_FLAG];
  wire logic stalled = txnIsIn ? cnf[FLD_STALL] : outStall_ff[txnIdx];

  // base register of the buffer this transaction will use
  // out X base is not held here, so an out request always reports the Y base
  wire logic [7:0] selBase = txnIsIn ? (useY ? inBbay_ff[txnIdx] : inBbax_ff[txnIdx]) : outBbay_ff[txnIdx];
  wire logic selPid = txnIsIn ? cnf[FLD_TOG] : outTog_ff[txnIdx];
  // input size word has no slot in the map, so an in request reports size 0
  wire logic [6:0] selSize = txnIsIn ? 7'h00 : outSiz_ff[txnIdx][6:0];

  // handshake priority: stall, then service gate, then flag nak
  ubd_hs_t nxtHs;
  always_comb begin
    if (!txnInRange || !usb_module_enable_ff) begin
      nxtHs = HS_NONE;
    end else if (stalled) begin
      nxtHs = HS_STALL; // R13
    end else if (txnIsIn && !cnf[FLD_SVC]) begin
      nxtHs = HS_NONE; // R10
    end else if (txnIsIn && inCount[FLD_FLAG]) begin
      nxtHs = HS_NAK; // R16
    end else if (!txnIsIn && useY && outFull) begin
      nxtHs = HS_NAK; // R4
    end else begin
      nxtHs = HS_ACK;
    end
  end

  // answer registers for the engine; outputs stay registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      txnHandshake <= HS_NONE;
      txnStartAddr <= 11'h000;
      txnByteCount <= 7'h00;
      txnDataPid <= 1'b0;
      txnValid <= 1'b0;
      txnBufSize <= 7'h00;
    end else begin
      txnValid <= txnReq;
      txnHandshake <= txnReq ? nxtHs : HS_NONE;
      txnStartAddr <= baseToAddr(selBase); // R1 R12 R21
      txnByteCount <= inCount[6:0];
      txnDataPid <= selPid; // R11
      txnBufSize <= selSize; // R6
    end
  end

  // request latch: the completion pulse comes one cycle after the request, when the engine
  // may already show another endpoint or direction; events must hit the endpoint answered
  logic [2:0] reqEp_ff;
  logic reqIsIn_ff;
  logic reqUseY_ff;
  logic reqIie_ff;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      reqEp_ff <= 3'h0;
      reqIsIn_ff <= 1'b0;
      reqUseY_ff <= 1'b0;
      reqIie_ff <= 1'b0;
    end else begin
      reqEp_ff <= txnEp;
      reqIsIn_ff <= txnIsIn;
      reqUseY_ff <= useY;
      reqIie_ff <= cnf[FLD_IIE];
    end
  end

  // the answered request was accepted; only then may a completion change state
  wire logic reqAck = txnValid && (txnHandshake == HS_ACK);

  // descriptor registers: software writes, hardware events; event set wins over a clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 1; i <= EP_NUM; i++) begin
        outBbay_ff[i] <= RST_BYTE;
        outBcty_ff[i] <= RST_BYTE;
        outSiz_ff[i] <= RST_BYTE;
        inCnf_ff[i] <= RST_BYTE;
        inBbax_ff[i] <= RST_BYTE;
        inBctx_ff[i] <= RST_BYTE;
        inBbay_ff[i] <= RST_BYTE;
        inBcty_ff[i] <= RST_IN_BCTY; // R19
      end
      outTog_ff <= '0;
      outStall_ff <= '0;
      outDbuf_ff <= '0;
    end else begin
      for (int i = 1; i <= EP_NUM; i++) begin
        if (regWr && regEp == 3'(i)) begin
          case (regIdx)
            IDX_OUT_BBAY: outBbay_ff[i] <= wByte;
            IDX_OUT_BCTY: outBcty_ff[i] <= wByte;
            IDX_OUT_SIZ: outSiz_ff[i] <= wByte & SIZ_MASK; // R6 R18
            IDX_IN_CNF: inCnf_ff[i] <= wByte & CNF_MASK; // R18
            IDX_IN_BBAX: inBbax_ff[i] <= wByte;
            IDX_IN_BCTX: inBctx_ff[i] <= wByte;
            IDX_IN_BBAY: inBbay_ff[i] <= wByte;
            IDX_IN_BCTY: inBcty_ff[i] <= wByte;
            default: ;
          endcase
        end
        // hardware events after the write so that a set beats a clear
        // a retransmitted packet with the old pid gets no toggle and no buffer flag, though outIrqFlag still pulses
        if (reqAck && reqEp_ff == 3'(i)) begin
          if (outDone && !reqIsIn_ff) begin
            if (outPidMatch) begin
              outTog_ff[i] <= ~outTog_ff[i]; // R20
              if (reqUseY_ff) begin
                outBcty_ff[i] <= {1'b1, outByteCount}; // R3 R5
              end
            end
          end
          // in side: flag marks the half just sent as empty
          if (inDone && reqIsIn_ff) begin
            inCnf_ff[i][FLD_TOG] <= ~inCnf_ff[i][FLD_TOG]; // R11
            if (reqUseY_ff) begin
              inBcty_ff[i][FLD_FLAG] <= 1'b1; // R15
            end else begin
              inBctx_ff[i][FLD_FLAG] <= 1'b1; // R15
            end
          end
        end
        if (setupSeen && setupEp == 3'(i)) begin
          inCnf_ff[i][FLD_STALL] <= 1'b0; // R13
          outStall_ff[i] <= 1'b0;
        end
      end
    end
  end

  // module enable in the control word; always writable
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      usb_module_enable_ff <= 1'b0;
    end else if (apbWrite && isCtrl) begin
      usb_module_enable_ff <= pwdata[0];
    end
  end

  // completion flags; the IN flag is gated by the per-endpoint irq enable, the OUT flag is not
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      outIrqFlag <= 8'h00;
      inIrqFlag <= 8'h00;
    end else begin
      outIrqFlag <= 8'h00;
      inIrqFlag <= 8'h00;
      // enable is taken with the request, so a config write in between does not matter
      if (reqAck && inDone && reqIsIn_ff && reqIie_ff) begin
        inIrqFlag[reqEp_ff] <= 1'b1; // R14
      end
      // out enable lives in the out config word, not held here
      if (reqAck && outDone && !reqIsIn_ff) begin
        outIrqFlag[reqEp_ff] <= 1'b1; // R14
      end
    end
  end

  // read mux
  logic [7:0] rdByte;
  always_comb begin
    rdByte = 8'h00;
    if (isCtrl) begin
      rdByte = {7'h00, usb_module_enable_ff};
    end else if (epHit) begin
      case (regIdx)
        IDX_OUT_BBAY: rdByte = outBbay_ff[regEp];
        IDX_OUT_BCTY: rdByte = outBcty_ff[regEp];
        IDX_OUT_SIZ: rdByte = outSiz_ff[regEp];
        IDX_IN_CNF: rdByte = inCnf_ff[regEp];
        IDX_IN_BBAX: rdByte = inBbax_ff[regEp];
        IDX_IN_BCTX: rdByte = inBctx_ff[regEp];
        IDX_IN_BBAY: rdByte = inBbay_ff[regEp];
        IDX_IN_BCTY: rdByte = inBcty_ff[regEp];
        default: rdByte = 8'h00;
      endcase
    end
  end

  // apb answer: no wait state, registered outputs
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
      usbModuleEnable <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= {24'h000000, rdByte};
      pslverr <= psel & ~penable & ~hit;
      usbModuleEnable <= usb_module_enable_ff;
    end
  end

endmodule // ubd_top

/* File: verif/ubd_chk.sv */
// checker for the descriptor block: apb timing, engine answers, read masks
// assumes bind onto ubd_top, one clock domain
`timescale 1ns/1ps
module ubd_chk (
  input logic clk_sys,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic txnReq,
  input logic txnValid,
  input logic [1:0] txnHandshake,
  input logic [10:0] txnStartAddr,
  input logic inDone,
  input logic [7:0] inIrqFlag,
  input logic usbModuleEnable
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // completed read of an endpoint word, offset in low five bits
  wire rdAcc = psel && penable && pready && !pwrite && paddr[11:5] != 7'h00;
  wire ctlWr = psel && penable && pready && pwrite && paddr == 12'h000;

  a_setup_ready: assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_enable_write: assert property (ctlWr |-> ##2 usbModuleEnable == $past(pwdata[0], 2))
    else $error("module enable not written");
  a_answer_req: assert property (txnReq |=> txnValid) else $error("no engine answer");
  a_addr_align: assert property (txnValid |-> txnStartAddr[2:0] == 3'h0) else $error("start addr low bits");
  a_size_rsvd: assert property (rdAcc && paddr[4:0] == 5'h08 |-> prdata[31:7] == 25'h0)
    else $error("size reserved bits set");
  a_cnf_rsvd: assert property (rdAcc && paddr[4:0] == 5'h0C |-> prdata[6] == 1'b0 && prdata[1:0] == 2'h0)
    else $error("config reserved bits set");
  a_irq_done: assert property (inIrqFlag != 8'h00 |-> $past(inDone) || $past(inDone, 2))
    else $error("irq flag without done");

  c_stall: cover property (txnValid && txnHandshake == 2'h2);
  c_nak: cover property (txnValid && txnHandshake == 2'h1);
  c_irq: cover property (inIrqFlag != 8'h00);
endmodule // ubd_chk
bind ubd_top ubd_chk u_chk(.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .txnReq(txnReq), .txnValid(txnValid),
  .txnHandshake(txnHandshake), .txnStartAddr(txnStartAddr), .inDone(inDone), .inIrqFlag(inIrqFlag),
  .usbModuleEnable(usbModuleEnable));

/* File: verif/ubd_host_model.sv */
// packet engine and host side: asks for endpoints, commits, sends setup
// assumes tasks are called just after a rising edge of clk_sys
`timescale 1ns/1ps
module ubd_host_model (
  input logic clk_sys,
  output logic txnReq,
  output logic txnIsIn,
  output logic [2:0] txnEp,
  output logic outDone,
  output logic outPidMatch,
  output logic [6:0] outByteCount,
  output logic inDone,
  output logic setupSeen,
  output logic [2:0] setupEp
);
  // idle levels; released endpoint lines show the inverse
  initial begin
    txnReq = 1'b0;
    txnIsIn = 1'b0;
    txnEp = 3'h0;
    outDone = 1'b0;
    outPidMatch = 1'b1;
    outByteCount = 7'h00;
    inDone = 1'b0;
    setupSeen = 1'b0;
    setupEp = 3'h0;
  end
  // commit only a transfer the host really took, a NAK sends nothing
  task automatic xfer(input logic isIn, input logic [2:0] ep, input logic done);
    txnReq <= 1'b1;
    txnIsIn <= isIn;
    txnEp <= ep;
    @(posedge clk_sys);
    txnReq <= 1'b0;
    txnEp <= ~ep;
    inDone <= done & isIn;
    outDone <= done & !isIn;
    @(posedge clk_sys);
    inDone <= 1'b0;
    outDone <= 1'b0;
  endtask
  // setup token for one endpoint
  task automatic setup(input logic [2:0] ep);
    setupSeen <= 1'b1;
    setupEp <= ep;
    @(posedge clk_sys);
    setupSeen <= 1'b0;
    setupEp <= ~ep;
  endtask
endmodule // ubd_host_model

/* File: verif/tb_top.sv */
// self-checking bench: apb software side plus engine model on endpoint 1
// assumes ubd_top, ubd_host_model and the bound checker
`timescale 1ns/1ps
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, txnReq, txnIsIn, outDone, outPidMatch, inDone, setupSeen, txnDataPid, txnValid, modEn;
  logic [2:0] txnEp, setupEp;
  logic [6:0] outByteCount, txnByteCount;
  logic [1:0] txnHandshake;
  logic [10:0] txnStartAddr;
  logic [7:0] inIrqFlag, b, c;
  logic [32:0] rdQ[$];
  logic [21:0] txQ[$], e;
  int n_fail = 0, cmp_count = 0;

  ubd_top u_dut(.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .txnReq(txnReq), .txnIsIn(txnIsIn),
    .txnEp(txnEp), .outDone(outDone), .outPidMatch(outPidMatch), .outByteCount(outByteCount), .inDone(inDone),
    .setupSeen(setupSeen), .setupEp(setupEp), .txnHandshake(txnHandshake), .txnStartAddr(txnStartAddr),
    .txnByteCount(txnByteCount), .txnDataPid(txnDataPid), .txnValid(txnValid), .txnBufSize(),
    .outIrqFlag(), .inIrqFlag(inIrqFlag), .usbModuleEnable(modEn));
  ubd_host_model u_host(.clk_sys(clk_sys), .txnReq(txnReq), .txnIsIn(txnIsIn), .txnEp(txnEp), .outDone(outDone),
    .outPidMatch(outPidMatch), .outByteCount(outByteCount), .inDone(inDone), .setupSeen(setupSeen),
    .setupEp(setupEp));

  always #20 clk_sys = ~clk_sys;

  function automatic logic [7:0] nextRand(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  // one apb transfer, read expectation noted at setup; extra edge keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rdQ.push_back({a == 12'h004, d}); // only the unmapped word errors
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (!pready);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  // IN request on endpoint 1 with its expected answer
  task automatic inTxn(input logic done, input logic [21:0] x);
    txQ.push_back(x);
    u_host.xfer(1'b1, 3'h1, done);
    @(posedge clk_sys);
  endtask
  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // monitors take the oldest note when a result shows
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, rdQ.pop_front());
    if (inIrqFlag != 8'h00) chk(inIrqFlag, 8'h02);
    if (txnValid) begin
      e = txQ.pop_front();
      chk(e[21] ? {txnHandshake, txnStartAddr, txnByteCount, txnDataPid} : {txnHandshake, 19'h0}, e[20:0]);
    end
  end
  // watchdog, far beyond the hundred or so cycles needed
  initial begin
    repeat (4000) @(posedge clk_sys);
    n_fail++;
    final_report;
  end
  initial begin
    b = nextRand(8'h23);
    c = nextRand(b);
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    apb(0, 12'h03C, 32'h80);
    apb(1, 12'h030, {24'h0, b});
    apb(0, 12'h030, 32'h0);
    apb(1, 12'h000, 32'h1);
    apb(1, 12'h028, 32'hFF);
    chk(modEn, 1'b1);
    apb(0, 12'h028, 32'h7F);
    apb(1, 12'h02C, 32'hFF);
    apb(0, 12'h02C, 32'hBC);
    apb(1, 12'h02C, 32'h84);
    apb(1, 12'h030, {24'h0, b});
    apb(1, 12'h034, 32'h05);
    inTxn(1, {1'b1, 2'h0, b, 3'h0, 7'h05, 1'b0});
    apb(0, 12'h034, 32'h85);
    apb(0, 12'h02C, 32'hA4);
    apb(0, 12'h030, {24'h0, b});
    inTxn(0, {1'b0, 2'h1, 19'h0});
    apb(1, 12'h02C, 32'h88);
    inTxn(0, {1'b0, 2'h2, 19'h0});
    u_host.setup(3'h1);
    apb(0, 12'h02C, 32'h80);
    apb(1, 12'h02C, 32'h90);
    apb(1, 12'h034, 32'h03);
    apb(1, 12'h038, {24'h0, c});
    apb(1, 12'h03C, 32'h07);
    inTxn(1, {1'b1, 2'h0, b, 3'h0, 7'h03, 1'b0});
    inTxn(1, {1'b1, 2'h0, c, 3'h0, 7'h07, 1'b1});
    apb(0, 12'h03C, 32'h87);
    apb(0, 12'h004, 32'h0);
    final_report;
  end
endmodule // tb_top
